/* File: rtl/sfe_eeprom.sv */
// Contract
// [RL1] Eight-bit instruction register selects the operation.
// [RL2] Input bits taken on rising clock while selected.
// [RL3] Host keeps select low, pause high throughout.
// [RL4] All fields travel most significant bit first.
// [RL5] First bit on first rise after select.
// [RL6] Pause freezes transaction; release resumes in place.
// [RL7] Write cycle starts at deselect, ends within 5 ms.
// [RL8] Holds 512 bytes addressed byte by byte.
// [RL9] While paused, only select is honoured.
// [RL10] Instruction carries ninth address bit in bit 3.
// [RL11] Output driven only while shifting read data.
// [RL12] Deselect aborts instruction and clears bit counter.
`timescale 1ns/1ps
module sfe_eeprom #(
   parameter int WRITE_CYC = sfe_pkg::WRITE_CYC
) (
   input  wire logic clk_sys,
   input  wire logic rstn,
   input  wire logic cs_n,
   input  wire logic sck,
   input  wire logic si,
   input  wire logic hold_n,
   output logic      so,
   output logic      so_oe
);
   localparam int WT_W = $clog2(WRITE_CYC + 1);
   localparam logic [WT_W-1:0] WT_LAST = WT_W'(WRITE_CYC - 1);

   sfe_pkg::sfe_pins_t  pins_s1, pins_s2;
   sfe_pkg::sfe_state_t state, next_state;
   logic                sel_d, sck_d;
   logic [2:0]          bitcnt, obit;
   logic [7:0]          sh, tx;
   logic [sfe_pkg::ADDR_W-1:0] addr;
   logic                is_wr, wr_sr, armed_op, latch_set, tx_live;
   logic                wel, wip;
   logic [1:0]          bp;
   logic [WT_W-1:0]     wtimer;
   logic [sfe_pkg::PAGE_W-1:0] cidx;
   logic [sfe_pkg::PAGE_BYTES-1:0] mask;
   logic [7:0]          mem [sfe_pkg::MEM_BYTES];
   logic [7:0]          pg  [sfe_pkg::PAGE_BYTES];
   logic [sfe_pkg::BUF_W-1:0] fifo [2];
   logic                wptr, rptr;
   logic [1:0]          fcnt;

   // Pins come from the host's domain, so each passes two flops first.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         pins_s1 <= sfe_pkg::PINS_IDLE;
         pins_s2 <= sfe_pkg::PINS_IDLE;
      end else begin
         pins_s1 <= '{cs_n: cs_n, sck: sck, si: si, hold_n: hold_n};
         pins_s2 <= pins_s1;
      end
   end

   wire sel      = ~pins_s2.cs_n;
   wire cs_rise  = sel_d & ~sel;
   wire cs_fall  = ~sel_d & sel;
   // [RL9] Pause masks clock edges
   wire paused   = sel & ~pins_s2.hold_n;
   // [RL2] Sample on rise only
   wire rise     = sel & ~paused & pins_s2.sck & ~sck_d;
   wire fall     = sel & ~paused & ~pins_s2.sck & sck_d;
   wire byte_end = rise & (bitcnt == sfe_pkg::BIT_LAST);
   // [RL4] Newest bit enters at the bottom
   wire [7:0] byte_in = {sh[6:0], pins_s2.si};
   wire [2:0] op      = byte_in[2:0];
   wire op_ok    = byte_in[7:4] == sfe_pkg::OP_PREFIX;
   wire wr_ok    = wel & ~wip;
   wire in_read  = (state == sfe_pkg::ST_RDATA) | (state == sfe_pkg::ST_SRD);
   wire [7:0] stat_byte = sfe_pkg::sfe_stat_t'{spare: 4'h0, bp: bp, wel: wel, wip: wip};
   wire       buf_in_rdy = fcnt != 2'h2;
   wire       buf_out_vld = fcnt != 2'h0;
   wire       push     = sel & in_read & buf_in_rdy;
   wire [7:0] push_dat = (state == sfe_pkg::ST_SRD) ? stat_byte : mem[addr];
   wire       pop      = fall & in_read & (obit == sfe_pkg::BIT_FIRST) & buf_out_vld;
   wire [7:0] pop_dat  = fifo[rptr];
   // [RL7] A write needs whole bytes and a deselect on a byte boundary
   wire arm_now  = ~wip & (bitcnt == sfe_pkg::BIT_FIRST) & ((state == sfe_pkg::ST_WDATA & |mask)
                   | (state == sfe_pkg::ST_DONE & wr_sr & mask[0]));
   // Status writes always use slot zero, whatever the address pointer left behind.
   wire [sfe_pkg::PAGE_W-1:0] pg_idx = (state == sfe_pkg::ST_SWR) ? '0
                                       : addr[sfe_pkg::PAGE_W-1:0];

   // [RL1] Instruction byte decode
   always_comb begin
      next_state = state;
      if (byte_end) begin
         case (state)
            sfe_pkg::ST_CMD: begin
               if (!op_ok) next_state = sfe_pkg::ST_DONE;
               // [RL10] Read and write carry the ninth address bit
               else if (op == sfe_pkg::OP_READ) next_state = wip ? sfe_pkg::ST_DONE : sfe_pkg::ST_ADDR;
               else if (op == sfe_pkg::OP_WRITE) next_state = wr_ok ? sfe_pkg::ST_ADDR : sfe_pkg::ST_DONE;
               else if (op == sfe_pkg::OP_RDSR) next_state = sfe_pkg::ST_SRD;
               else if (op == sfe_pkg::OP_WRSR) next_state = wr_ok ? sfe_pkg::ST_SWR : sfe_pkg::ST_DONE;
               else next_state = sfe_pkg::ST_DONE;
            end
            sfe_pkg::ST_ADDR: next_state = is_wr ? sfe_pkg::ST_WDATA : sfe_pkg::ST_RDATA;
            sfe_pkg::ST_SWR:  next_state = sfe_pkg::ST_DONE;
            default:          next_state = state;
         endcase
      end
      // [RL5] A fresh select starts the instruction byte
      if (cs_fall) next_state = sfe_pkg::ST_CMD;
      // [RL12] Deselect aborts whatever was in flight
      if (!sel) next_state = sfe_pkg::ST_IDLE;
   end

   // [RL6] Bit position and state move only on unpaused edges or a change of select
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state  <= sfe_pkg::ST_IDLE;
         bitcnt <= sfe_pkg::BIT_FIRST;
         sel_d  <= 1'b0;
         sck_d  <= 1'b0;
         sh     <= 8'h00;
      end else begin
         state  <= next_state;
         sel_d  <= sel;
         sck_d  <= pins_s2.sck;
         if (!sel) bitcnt <= sfe_pkg::BIT_FIRST;
         else if (rise) bitcnt <= bitcnt + 3'h1;
         if (rise) sh <= byte_in;
      end
   end

   // Address pointer, operation flags and page collection.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         addr <= '0;
         is_wr <= 1'b0;
         wr_sr <= 1'b0;
         armed_op <= 1'b0;
         latch_set <= 1'b0;
         mask <= '0;
      end else begin
         if (cs_fall) begin
            armed_op <= 1'b0;
            if (!wip) wr_sr <= 1'b0;
            if (!wip) mask <= '0;
         end
         // A status poll during a write cycle must not disturb its kind or target.
         if (byte_end && state == sfe_pkg::ST_CMD && op_ok) begin
            if (!wip) is_wr <= op == sfe_pkg::OP_WRITE;
            if (!wip) wr_sr <= op == sfe_pkg::OP_WRSR;
            armed_op <= (op == sfe_pkg::OP_WREN) | (op == sfe_pkg::OP_WRDI);
            latch_set <= op == sfe_pkg::OP_WREN;
            if (!wip) addr[sfe_pkg::ADDR_W-1] <= byte_in[sfe_pkg::A8_BIT];
         end else if (byte_end) begin
            armed_op <= 1'b0;
         end
         if (byte_end && state == sfe_pkg::ST_ADDR) addr[7:0] <= byte_in;
         if (byte_end && (state == sfe_pkg::ST_WDATA || state == sfe_pkg::ST_SWR)) begin
            mask[pg_idx] <= 1'b1;
         end
         // Page writes wrap inside the page rather than spill into the next one.
         if (byte_end && state == sfe_pkg::ST_WDATA) begin
            addr[sfe_pkg::PAGE_W-1:0] <= addr[sfe_pkg::PAGE_W-1:0] + 4'h1;
         end
         if (byte_end && state == sfe_pkg::ST_SWR) addr[sfe_pkg::PAGE_W-1:0] <= '0;
         // [RL8] Reads walk the whole array and roll over at the top
         if (push && state == sfe_pkg::ST_RDATA) addr <= addr + 9'h001;
         if (wip && wtimer == WT_LAST) mask <= '0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (byte_end && (state == sfe_pkg::ST_WDATA || state == sfe_pkg::ST_SWR)) begin
         pg[pg_idx] <= byte_in;
      end
      // [RL8] Page is copied into the array while the cycle runs
      if (wip && !wr_sr && wtimer < WT_W'(sfe_pkg::PAGE_BYTES) && mask[cidx]) begin
         mem[{addr[sfe_pkg::ADDR_W-1:sfe_pkg::PAGE_W], cidx}] <= pg[cidx];
      end
   end

   // [RL7] Self-timed write cycle
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wip <= 1'b0;
         wel <= 1'b0;
         bp <= 2'h0;
         wtimer <= '0;
         cidx <= '0;
      end else begin
         if (wip) begin
            wtimer <= wtimer + WT_W'(1);
            cidx <= cidx + 4'h1;
         end
         if (wip && wtimer == WT_LAST) begin
            wip <= 1'b0;
            wel <= 1'b0;
            if (wr_sr) bp <= pg[0][sfe_pkg::BP_LSB +: 2];
         end
         if (cs_rise && armed_op && bitcnt == sfe_pkg::BIT_FIRST && !latch_set) wel <= 1'b0;
         // A set arriving with the end of a write cycle wins over its clear.
         if (cs_rise && armed_op && bitcnt == sfe_pkg::BIT_FIRST && latch_set) wel <= 1'b1;
         if (cs_rise && arm_now) begin
            wip <= 1'b1;
            wtimer <= '0;
            cidx <= '0;
         end
      end
   end

   // Two-entry buffer lets the fetch run ahead of the slow serial shifter.
   always_ff @(posedge clk_sys) begin
      if (!rstn || !sel) begin
         wptr <= 1'b0;
         rptr <= 1'b0;
         fcnt <= 2'h0;
      end else begin
         if (push) wptr <= ~wptr;
         if (pop) rptr <= ~rptr;
         fcnt <= fcnt + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) fifo[wptr] <= push_dat;
   end

   // [RL4] Data leaves most significant bit first on falling edges
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         tx <= 8'h00;
         obit <= sfe_pkg::BIT_FIRST;
         so <= 1'b0;
         so_oe <= 1'b0;
         tx_live <= 1'b0;
      end else begin
         if (!sel) obit <= sfe_pkg::BIT_FIRST;
         else if (pop) begin
            so <= pop_dat[7];
            tx <= {pop_dat[6:0], 1'b0};
            obit <= sfe_pkg::BIT_LAST;
         end else if (fall && obit != sfe_pkg::BIT_FIRST) begin
            so <= tx[7];
            tx <= {tx[6:0], 1'b0};
            obit <= obit - 3'h1;
         end
         tx_live <= sel & (tx_live | pop);
         // [RL11] High impedance when deselected or paused
         so_oe <= (tx_live | pop) & sel & ~paused;
      end
   end

   sequence s_byte_end;
      rise && bitcnt == 3'h7;
   endsequence

   sequence s_deselect;
      sel_d && !sel;
   endsequence

   chk_cmd_leaves: assert property (@(posedge clk_sys) disable iff (!rstn)  // [RL1]
      s_byte_end ##0 (state == sfe_pkg::ST_CMD && sel) |=> state != sfe_pkg::ST_CMD)
      else $error("instruction byte not consumed");
   chk_rise_only: assert property (@(posedge clk_sys) disable iff (!rstn)  // [RL2]
      !rise |=> $stable(sh))
      else $error("input shifted without a rising edge");
   chk_msb_first: assert property (@(posedge clk_sys) disable iff (!rstn)  // [RL4]
      (fall && in_read && obit != 3'h0 && !pop) |=> so == $past(tx[7]))
      else $error("output bit order wrong");
   chk_first_bit: assert property (@(posedge clk_sys) disable iff (!rstn)  // [RL5]
      (!sel_d && sel) |=> state == sfe_pkg::ST_CMD && bitcnt == 3'h0)
      else $error("new select did not start at bit zero");
   chk_pause_freeze: assert property (@(posedge clk_sys) disable iff (!rstn)  // [RL6]
      (paused && sel) [*2] |=> $stable(bitcnt) && $stable(state) && $stable(obit))
      else $error("transaction moved while paused");
   chk_write_start: assert property (@(posedge clk_sys) disable iff (!rstn)  // [RL7]
      s_deselect ##0 arm_now |=> wip && wtimer == '0)
      else $error("write cycle did not start at deselect");
   chk_write_bound: assert property (@(posedge clk_sys) disable iff (!rstn)  // [RL7]
      wip |-> wtimer <= WT_LAST)
      else $error("write cycle overran its limit");
   chk_addr_wrap: assert property (@(posedge clk_sys) disable iff (!rstn)  // [RL8]
      (push && state == sfe_pkg::ST_RDATA && addr == 9'h1ff) |=> addr == 9'h000)
      else $error("read address did not roll over");
   chk_read_decode: assert property (@(posedge clk_sys) disable iff (!rstn)  // [RL10]
      s_byte_end ##0 (sel && state == sfe_pkg::ST_CMD && op_ok && op == sfe_pkg::OP_READ && !wip)
      |=> state == sfe_pkg::ST_ADDR && addr[8] == $past(byte_in[3]))
      else $error("read instruction decoded wrongly");
   chk_so_hiz: assert property (@(posedge clk_sys) disable iff (!rstn)  // [RL11]
      (!sel || paused) |=> !so_oe)
      else $error("output driven while idle or paused");
   chk_cs_abort: assert property (@(posedge clk_sys) disable iff (!rstn)  // [RL12]
      s_deselect |=> bitcnt == 3'h0 && state == sfe_pkg::ST_IDLE)
      else $error("deselect did not abort the instruction");
endmodule : sfe_eeprom

/* File: rtl/sfe_pkg.sv */
// Shared constants and types for the serial EEPROM front end.
package sfe_pkg;
   localparam int CLK_HZ     = 10_000_000;
   localparam int T_WRITE_MS = 5;
   // Longest write time rounds down to whole cycles.
   localparam int WRITE_CYC  = T_WRITE_MS * (CLK_HZ / 1000);
   localparam int MEM_BYTES  = 512;
   localparam int ADDR_W     = 9;
   localparam int PAGE_BYTES = 16;
   localparam int PAGE_W     = 4;
   localparam int BUF_W      = 8;
   localparam int A8_BIT     = 3;
   localparam int BP_LSB     = 2;

   localparam logic [3:0] OP_PREFIX = 4'h0;
   localparam logic [2:0] OP_READ   = 3'h3;
   localparam logic [2:0] OP_WRITE  = 3'h2;
   localparam logic [2:0] OP_WRDI   = 3'h4;
   localparam logic [2:0] OP_WREN   = 3'h6;
   localparam logic [2:0] OP_RDSR   = 3'h5;
   localparam logic [2:0] OP_WRSR   = 3'h1;
   localparam logic [2:0] BIT_LAST  = 3'h7;
   localparam logic [2:0] BIT_FIRST = 3'h0;

   typedef enum logic [2:0] {
      ST_IDLE, ST_CMD, ST_ADDR, ST_RDATA, ST_WDATA, ST_SRD, ST_SWR, ST_DONE
   } sfe_state_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic hold_n;
   } sfe_pins_t;

   localparam sfe_pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1};

   typedef struct packed {
      logic [3:0] spare;
      logic [1:0] bp;
      logic       wel;
      logic       wip;
   } sfe_stat_t;
endpackage : sfe_pkg

/* File: dv/sfe_host.sv */
// Behavioural serial host that drives the pins of the front end.
`timescale 1ns/1ps
module sfe_host (
   input  wire logic          clk_sys,
   input  wire logic          so,
   output sfe_pkg::sfe_pins_t pins
);
   initial pins = sfe_pkg::PINS_IDLE;

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask : tick

   task automatic frame_open();
      @(posedge clk_sys) pins.sck <= 1'b0;
      tick(4);
      pins.cs_n <= 1'b0;
      tick(4);
   endtask : frame_open

   task automatic frame_close();
      @(posedge clk_sys) pins.sck <= 1'b0;
      tick(4);
      pins.cs_n <= 1'b1;
      // A released data line flips, so a stale level is never mistaken for data.
      pins.si <= ~pins.si;
      tick(4);
   endtask : frame_close

   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         @(posedge clk_sys) pins.sck <= 1'b0;
         pins.si <= tx[i];
         tick(4);
         pins.sck <= 1'b1;
         tick(2);
         rx[i] = so;
         tick(1);
      end
   endtask : xfer

   task automatic pause(input int n);
      @(posedge clk_sys) pins.sck <= 1'b0;
      tick(4);
      pins.hold_n <= 1'b0;
      tick(4);
      for (int i = 0; i < 2 * n; i++) begin
         pins.sck <= ~pins.sck;
         pins.si <= ~pins.si;
         tick(4);
      end
      pins.hold_n <= 1'b1;
      tick(4);
   endtask : pause
endmodule : sfe_host

/* File: dv/sfe_eeprom_test.sv */
// Self-checking bench for the serial EEPROM front end.
`timescale 1ns/1ps
module sfe_eeprom_test;
   // Short write cycle keeps polling cheap; must stay above 16.
   localparam int WCYC = 160;
   logic               clk_sys = 1'b0;
   logic               rstn = 1'b0;
   logic               so;
   logic               so_oe;
   wire                so_w = so_oe ? so : 1'bz;
   sfe_pkg::sfe_pins_t pins;
   int                 failures = 0;
   int                 samples_checked = 0;

   always #50 clk_sys = ~clk_sys;

   sfe_eeprom #(.WRITE_CYC(WCYC)) sfe_eeprom_inst (
      .clk_sys(clk_sys), .rstn(rstn), .cs_n(pins.cs_n), .sck(pins.sck),
      .si(pins.si), .hold_n(pins.hold_n), .so(so), .so_oe(so_oe));
   sfe_host sfe_host_inst (.clk_sys(clk_sys), .so(so_w), .pins(pins));

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test

   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : cmp8

   task automatic cmp1(input logic got, input logic exp);
      cmp8({7'h00, got}, {7'h00, exp});
   endtask : cmp1

   task automatic cmd(input logic [7:0] c);
      logic [7:0] r;
      sfe_host_inst.frame_open();
      sfe_host_inst.xfer(c, 8, r);
      sfe_host_inst.frame_close();
   endtask : cmd

   task automatic rdsr_raw(output logic [7:0] r);
      sfe_host_inst.frame_open();
      sfe_host_inst.xfer({sfe_pkg::OP_PREFIX, 1'b0, sfe_pkg::OP_RDSR}, 8, r);
      sfe_host_inst.xfer(8'h00, 8, r);
      sfe_host_inst.frame_close();
   endtask : rdsr_raw

   task automatic rdsr(input logic [7:0] exp);
      logic [7:0] r;
      rdsr_raw(r);
      cmp8(r, exp);
   endtask : rdsr

   task automatic rd(input logic [8:0] a, input logic [7:0] exp, input logic hold);
      logic [7:0] r;
      sfe_host_inst.frame_open();
      sfe_host_inst.xfer({sfe_pkg::OP_PREFIX, a[8], sfe_pkg::OP_READ}, 8, r);
      sfe_host_inst.xfer(a[7:0], 8, r);
      if (hold) begin
         sfe_host_inst.pause(3);
      end
      sfe_host_inst.xfer(8'h00, 8, r);
      sfe_host_inst.frame_close();
      cmp8(r, exp);
      cmp1(so_oe, 1'b0);
   endtask : rd

   task automatic t_write();
      logic [7:0] r;
      cmd({sfe_pkg::OP_PREFIX, 1'b0, sfe_pkg::OP_WREN});
      rdsr(8'h02);
      sfe_host_inst.frame_open();
      sfe_host_inst.xfer({sfe_pkg::OP_PREFIX, 1'b1, sfe_pkg::OP_WRITE}, 8, r);
      sfe_host_inst.xfer(8'hff, 8, r);
      sfe_host_inst.xfer(8'ha5, 8, r);
      sfe_host_inst.xfer(8'h3c, 8, r);
      sfe_host_inst.frame_close();
      rdsr(8'h03);
      rdsr(8'h00);
      rd(9'h1ff, 8'ha5, 1'b0);
      $display("test write done");
   endtask : t_write

   task automatic t_pause();
      // The second byte wrapped inside the page, so it sits at the page start.
      rd(9'h1f0, 8'h3c, 1'b0);
      fork
         rd(9'h1f0, 8'h3c, 1'b1);
         begin
            // Midway through the pause the output must be released.
            repeat (160) @(posedge clk_sys);
            cmp1(so_oe, 1'b0);
         end
      join
      $display("test pause done");
   endtask : t_pause

   task automatic t_abort();
      logic [7:0] r;
      sfe_host_inst.frame_open();
      sfe_host_inst.xfer({sfe_pkg::OP_PREFIX, 1'b0, sfe_pkg::OP_WREN}, 7, r);
      sfe_host_inst.frame_close();
      rdsr(8'h00);
      $display("test abort done");
   endtask : t_abort

   task automatic t_status();
      logic [7:0] r;
      int         k;
      cmd({sfe_pkg::OP_PREFIX, 1'b0, sfe_pkg::OP_WREN});
      sfe_host_inst.frame_open();
      sfe_host_inst.xfer({sfe_pkg::OP_PREFIX, 1'b0, sfe_pkg::OP_WRSR}, 8, r);
      sfe_host_inst.xfer(8'h0c, 8, r);
      sfe_host_inst.frame_close();
      for (k = 0; k < 10; k++) begin
         rdsr_raw(r);
         if (r[0] === 1'b0) begin
            break;
         end
      end
      if (k == 10) begin
         failures++;
         stop_test();
      end
      rdsr(8'h0c);
      cmd({sfe_pkg::OP_PREFIX, 1'b0, sfe_pkg::OP_WREN});
      rdsr(8'h0e);
      cmd({sfe_pkg::OP_PREFIX, 1'b0, sfe_pkg::OP_WRDI});
      rdsr(8'h0c);
      $display("test status done");
   endtask : t_status

   initial begin
      repeat (16) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      cmp1(so_oe, 1'b0);
      t_write();
      t_pause();
      t_abort();
      t_status();
      stop_test();
   end
endmodule : sfe_eeprom_test
